// ==== logic/logic_cell_register_control.v ====
// array block control-signal selection driving its cell registers
// assumes all inputs synchronous to CORE_CLK_I; block clock levels are sampled here to make edge enables
// Function
// - block makes clock, enable, async and sync controls; at most six used
// - two clock lines, each tied to its own clock enable
// - same clock, different enables: use both lines or another block
// - both clock edges in a block use both clock lines
// - counter mode: count table, carry table, load selector, clear gate
// - sync clear or load beats the cascade chain value
// - sync clear beats sync load
// - arithmetic cells give registered and unregistered results together
// - block-wide clear and preset; cell register natively async clear only
// - emulated preset, preset-and-clear or load cost three cells each
// - emulated preset-and-load register is undefined after device clear
// - device-wide clear resets all registers, used per build option
// - device-wide clear beats every other control
// - preset registers go to one under device-wide clear
`timescale 1ns/1ps
`default_nettype none
`include "cell_ctrl_defines.vh"
module logic_cell_register_control #(
	parameter NUM_CELLS = 8,
	parameter DEV_CLEAR_USED = 1
) (
	input wire CORE_CLK_I,
	input wire RST_I,
	input wire DEVICE_WIDE_CLEAR_N_I,
	input wire BLOCK_CLOCK_ONE_I,
	input wire BLOCK_CLOCK_TWO_I,
	input wire BLOCK_CLOCK_ENABLE_ONE_I,
	input wire BLOCK_CLOCK_ENABLE_TWO_I,
	input wire ASYNC_CLEAR_I,
	input wire ASYNC_PRESET_I,
	input wire ASYNC_LOAD_I,
	input wire SYNC_CLEAR_I,
	input wire SYNC_LOAD_I,
	input wire [NUM_CELLS-1:0] CELL_CLOCK_SEL_I,
	input wire [NUM_CELLS-1:0] CELL_FALL_EDGE_I,
	input wire [2*NUM_CELLS-1:0] CELL_MODE_I,
	input wire [NUM_CELLS-1:0] CASCADE_USE_I,
	input wire [NUM_CELLS-1:0] CASCADE_I,
	input wire [NUM_CELLS-1:0] DATA_A_I,
	input wire [NUM_CELLS-1:0] DATA_B_I,
	input wire [NUM_CELLS-1:0] LOAD_DATA_I,
	input wire [7:0] COUNT_LUT_I,
	input wire [7:0] CARRY_LUT_I,
	input wire CARRY_IN_I,
	output reg [NUM_CELLS-1:0] REG_Q_O,
	output reg [NUM_CELLS-1:0] COMB_O,
	output reg CARRY_OUT_O,
	output reg [NUM_CELLS-1:0] UNKNOWN_O,
	output reg [3:0] CTRL_USED_O,
	output reg CTRL_OVER_O,
	output reg EDGE_CONFLICT_O,
	output reg [5:0] EXTRA_CELLS_O
);
	////////////////////////////////////////////////////////////////////////////
	// control selection
	reg block_clock_one_d;
	reg clk2_d;
	wire rise1;
	wire rise2;
	wire fall1;
	wire fall2;
	wire dev_clear;
	wire [3:0] used_cnt;
	wire [NUM_CELLS-1:0] q_w;
	wire [NUM_CELLS-1:0] comb_w;
	wire [NUM_CELLS-1:0] unk_w;
	wire [NUM_CELLS:0] carry_w;
	reg [5:0] next_extra;
	integer k;

	function [0:0] is_emulated;
		input [1:0] m;
		begin
			is_emulated = (m != `RMODE_CLEAR);
		end
	endfunction

	// option selects use of the pin
	assign dev_clear = RST_I | ((DEV_CLEAR_USED != 0) & ~DEVICE_WIDE_CLEAR_N_I);

	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			block_clock_one_d <= 1'b0;
			clk2_d <= 1'b0;
		end else begin
			block_clock_one_d <= BLOCK_CLOCK_ONE_I;
			clk2_d <= BLOCK_CLOCK_TWO_I;
		end
	end
	assign rise1 = BLOCK_CLOCK_ONE_I & ~block_clock_one_d;
	assign rise2 = BLOCK_CLOCK_TWO_I & ~clk2_d;
	assign fall1 = ~BLOCK_CLOCK_ONE_I & block_clock_one_d;
	assign fall2 = ~BLOCK_CLOCK_TWO_I & clk2_d;

	assign used_cnt = {3'h0, BLOCK_CLOCK_ENABLE_ONE_I} + {3'h0, BLOCK_CLOCK_ENABLE_TWO_I}
		+ {3'h0, ASYNC_CLEAR_I} + {3'h0, ASYNC_PRESET_I} + {3'h0, ASYNC_LOAD_I}
		+ {3'h0, SYNC_CLEAR_I} + {3'h0, SYNC_LOAD_I}
		+ {3'h0, |CELL_CLOCK_SEL_I} + {3'h0, ~&CELL_CLOCK_SEL_I};

	assign carry_w[0] = CARRY_IN_I;

	genvar g;
	generate
		for (g = 0; g < NUM_CELLS; g = g + 1) begin : cells
			wire sel2;
			wire edge_en;
			wire en;
			assign sel2 = CELL_CLOCK_SEL_I[g];
			// each edge from its own line
			assign edge_en = sel2 ? (CELL_FALL_EDGE_I[g] ? fall2 : rise2)
				: (CELL_FALL_EDGE_I[g] ? fall1 : rise1);
			// enable fixed to its clock line
			assign en = sel2 ? BLOCK_CLOCK_ENABLE_TWO_I : BLOCK_CLOCK_ENABLE_ONE_I;
			cell_register u_cell (
				.clk_i(CORE_CLK_I),
				.dev_clear_i(dev_clear),
				.mode_i(CELL_MODE_I[2*g+1:2*g]),
				.edge_en_i(edge_en),
				.clk_en_i(en),
				.async_clear_i(ASYNC_CLEAR_I),
				.async_preset_i(ASYNC_PRESET_I),
				.async_load_i(ASYNC_LOAD_I),
				.load_data_i(LOAD_DATA_I[g]),
				.sync_clear_i(SYNC_CLEAR_I),
				.sync_load_i(SYNC_LOAD_I),
				.cascade_use_i(CASCADE_USE_I[g]),
				.cascade_i(CASCADE_I[g]),
				.data_a_i(DATA_A_I[g]),
				.data_b_i(DATA_B_I[g]),
				.carry_i(carry_w[g]),
				.count_lut_i(COUNT_LUT_I),
				.carry_lut_i(CARRY_LUT_I),
				.q_o(q_w[g]),
				.comb_o(comb_w[g]),
				.carry_o(carry_w[g+1]),
				.unknown_o(unk_w[g])
			);
		end
	endgenerate

	always @* begin
		next_extra = 6'h00;
		for (k = 0; k < NUM_CELLS; k = k + 1) begin
			if (is_emulated(CELL_MODE_I[2*k +: 2])) begin
				next_extra = next_extra + {2'h0, `EMUL_EXTRA_CELLS};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			REG_Q_O <= {NUM_CELLS{1'b0}};
			COMB_O <= {NUM_CELLS{1'b0}};
			CARRY_OUT_O <= 1'b0;
			UNKNOWN_O <= {NUM_CELLS{1'b0}};
			CTRL_USED_O <= 4'h0;
			CTRL_OVER_O <= 1'b0;
			EDGE_CONFLICT_O <= 1'b0;
			EXTRA_CELLS_O <= 6'h00;
		end else begin
			REG_Q_O <= q_w;
			COMB_O <= comb_w;
			CARRY_OUT_O <= carry_w[NUM_CELLS];
			UNKNOWN_O <= unk_w;
			CTRL_USED_O <= used_cnt;
			CTRL_OVER_O <= (used_cnt > `MAX_CTRL_SIGNALS);
			// mixed edges on one line flagged
			EDGE_CONFLICT_O <= (|(CELL_FALL_EDGE_I & ~CELL_CLOCK_SEL_I)
				& |(~CELL_FALL_EDGE_I & ~CELL_CLOCK_SEL_I))
				| (|(CELL_FALL_EDGE_I & CELL_CLOCK_SEL_I)
				& |(~CELL_FALL_EDGE_I & CELL_CLOCK_SEL_I));
			EXTRA_CELLS_O <= next_extra;
		end
	end
endmodule
`default_nettype wire

// ==== logic/cell_ctrl_defines.vh ====
// constants for the array block register control logic
// assumes inclusion by both design files
`ifndef CELL_CTRL_DEFINES_VH
`define CELL_CTRL_DEFINES_VH
`define MAX_CTRL_SIGNALS 4'h6
`define EMUL_EXTRA_CELLS 4'h3
`define NUM_CELLS 4'h8
`define CTRL_CNT_W 4
// per-cell register modes
`define RMODE_W 2
`define RMODE_CLEAR 2'h0
`define RMODE_PRESET 2'h1
`define RMODE_PRE_AND_CLR 2'h2
`define RMODE_PRE_AND_LOAD 2'h3
`endif

// ==== logic/cell_register.v ====
// one counter-mode cell register with clear, preset and load handling
// assumes enables are one-cycle qualifiers on the single clock
`timescale 1ns/1ps
`default_nettype none
`include "cell_ctrl_defines.vh"
module cell_register (
	input wire clk_i,
	input wire dev_clear_i,
	input wire [1:0] mode_i,
	input wire edge_en_i,
	input wire clk_en_i,
	input wire async_clear_i,
	input wire async_preset_i,
	input wire async_load_i,
	input wire load_data_i,
	input wire sync_clear_i,
	input wire sync_load_i,
	input wire cascade_use_i,
	input wire cascade_i,
	input wire data_a_i,
	input wire data_b_i,
	input wire carry_i,
	input wire [7:0] count_lut_i,
	input wire [7:0] carry_lut_i,
	output reg q_o,
	output wire comb_o,
	output wire carry_o,
	output reg unknown_o
);
	wire [2:0] lut_idx;
	wire count_val;
	wire count_casc;
	wire muxed;
	wire next_q;
	wire emul_pre;
	assign lut_idx = {carry_i, data_b_i, data_a_i};
	assign count_val = count_lut_i[lut_idx];
	assign carry_o = carry_lut_i[lut_idx];
	assign count_casc = cascade_use_i ? (count_val & cascade_i) : count_val;
	assign comb_o = count_casc;
	assign muxed = sync_load_i ? load_data_i : count_casc;
	assign next_q = muxed & ~sync_clear_i;
	assign emul_pre = (mode_i == `RMODE_PRESET) || (mode_i == `RMODE_PRE_AND_CLR);
	always @(posedge clk_i) begin
		if (dev_clear_i) begin
			q_o <= emul_pre;
			unknown_o <= (mode_i == `RMODE_PRE_AND_LOAD);
		end else if (async_clear_i && !(emul_pre && async_preset_i)) begin
			q_o <= 1'b0;
			unknown_o <= 1'b0;
		end else if (async_preset_i && mode_i != `RMODE_CLEAR) begin
			q_o <= 1'b1;
			unknown_o <= 1'b0;
		end else if (async_load_i && mode_i != `RMODE_CLEAR) begin
			q_o <= load_data_i;
			unknown_o <= 1'b0;
		end else if (edge_en_i && clk_en_i) begin
			q_o <= next_q;
			unknown_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== test/lcrc_chk.sv ====
// checker: device clear, sync priority, enable pairing, status outputs
// assumes binding into logic_cell_register_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lcrc_chk #(parameter NUM_CELLS = 8) (
	input wire CORE_CLK_I,
	input wire RST_I,
	input wire DEVICE_WIDE_CLEAR_N_I,
	input wire BLOCK_CLOCK_ONE_I,
	input wire BLOCK_CLOCK_ENABLE_ONE_I,
	input wire ASYNC_CLEAR_I,
	input wire ASYNC_PRESET_I,
	input wire ASYNC_LOAD_I,
	input wire SYNC_CLEAR_I,
	input wire SYNC_LOAD_I,
	input wire [NUM_CELLS-1:0] CELL_CLOCK_SEL_I,
	input wire [NUM_CELLS-1:0] CELL_FALL_EDGE_I,
	input wire [2*NUM_CELLS-1:0] CELL_MODE_I,
	input wire [NUM_CELLS-1:0] LOAD_DATA_I,
	input wire [NUM_CELLS-1:0] REG_Q_O,
	input wire [NUM_CELLS-1:0] UNKNOWN_O,
	input wire [3:0] CTRL_USED_O,
	input wire CTRL_OVER_O,
	input wire [5:0] EXTRA_CELLS_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	wire quiet = DEVICE_WIDE_CLEAR_N_I && !ASYNC_CLEAR_I && !ASYNC_PRESET_I && !ASYNC_LOAD_I;
	////////////////////
	sequence s_clr(m);
		(!DEVICE_WIDE_CLEAR_N_I && CELL_MODE_I == m)[*2];
	endsequence
	// rising edge on line one, enabled, all cells on it
	sequence s_tick;
		$rose(BLOCK_CLOCK_ONE_I) && BLOCK_CLOCK_ENABLE_ONE_I && quiet
			&& CELL_CLOCK_SEL_I == 0 && CELL_FALL_EDGE_I == 0;
	endsequence
	////////////////////
	property p_clr_zero;
		s_clr({NUM_CELLS{2'h0}}) |=> REG_Q_O == 0;
	endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("clear mode not zero");
	property p_clr_one;
		s_clr({NUM_CELLS{2'h1}}) |=> REG_Q_O == {NUM_CELLS{1'b1}};
	endproperty
	a_clr_one: assert property (p_clr_one) else $error("preset mode not one");
	property p_unknown;
		s_clr({NUM_CELLS{2'h3}}) |=> ##[0:1] UNKNOWN_O == {NUM_CELLS{1'b1}};
	endproperty
	a_unknown: assert property (p_unknown) else $error("undefined flag missing");
	property p_extra;
		EXTRA_CELLS_O % 3 == 0 && EXTRA_CELLS_O <= 3 * NUM_CELLS;
	endproperty
	a_extra: assert property (p_extra) else $error("extra cell count bad");
	property p_over;
		CTRL_OVER_O == (CTRL_USED_O > 4'h6);
	endproperty
	a_over: assert property (p_over) else $error("over flag wrong");
	property p_sclr;
		s_tick ##0 SYNC_CLEAR_I |=> ##1 REG_Q_O == 0;
	endproperty
	a_sclr: assert property (p_sclr) else $error("sync clear lost");
	property p_sload;
		s_tick ##0 (!SYNC_CLEAR_I && SYNC_LOAD_I) |=> ##1 REG_Q_O == $past(LOAD_DATA_I, 2);
	endproperty
	a_sload: assert property (p_sload) else $error("sync load lost");
	property p_hold;
		(!BLOCK_CLOCK_ENABLE_ONE_I && quiet && CELL_CLOCK_SEL_I == 0 && CELL_MODE_I == 0)[*3]
			|-> $stable(REG_Q_O);
	endproperty
	a_hold: assert property (p_hold) else $error("update without enable");
endmodule
bind logic_cell_register_control lcrc_chk #(.NUM_CELLS(NUM_CELLS)) u_chk (.*);
`default_nettype wire

// ==== test/logic_cell_register_control_test.sv ====
// bench for the array block register control
// assumes default parameters, eight cells
`timescale 1ns/1ps
`default_nettype none
module logic_cell_register_control_test;
	logic CORE_CLK_I = 0, RST_I = 1, DEVICE_WIDE_CLEAR_N_I = 1, BLOCK_CLOCK_ONE_I = 0;
	logic BLOCK_CLOCK_TWO_I = 0, BLOCK_CLOCK_ENABLE_ONE_I = 1, BLOCK_CLOCK_ENABLE_TWO_I = 0;
	logic ASYNC_CLEAR_I = 0, ASYNC_PRESET_I = 0, ASYNC_LOAD_I = 0, CARRY_IN_I = 0;
	logic SYNC_CLEAR_I = 0, SYNC_LOAD_I = 0;
	logic [7:0] CELL_CLOCK_SEL_I = 0, CELL_FALL_EDGE_I = 0, CASCADE_USE_I = 8'hFF, CASCADE_I = 0;
	logic [7:0] DATA_A_I = 0, DATA_B_I = 0, LOAD_DATA_I = 0, COUNT_LUT_I = 0, CARRY_LUT_I = 0;
	logic [15:0] CELL_MODE_I = 0;
	wire [7:0] REG_Q_O, COMB_O, UNKNOWN_O;
	wire CARRY_OUT_O, CTRL_OVER_O, EDGE_CONFLICT_O;
	wire [3:0] CTRL_USED_O;
	wire [5:0] EXTRA_CELLS_O;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	logic_cell_register_control DUT (.*);
	initial forever #5 CORE_CLK_I = ~CORE_CLK_I;
	////////////////////
	task chk(input logic [7:0] a, input logic [7:0] e);
		cmp_count++;
		if (a !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, a, e);
		end
	endtask
	task pulse;
		@(posedge CORE_CLK_I) BLOCK_CLOCK_ONE_I <= 1;
		@(posedge CORE_CLK_I) BLOCK_CLOCK_ONE_I <= 0;
		repeat (3) @(posedge CORE_CLK_I);
		#1;
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////
	task t_sync;
		@(posedge CORE_CLK_I);
		SYNC_LOAD_I <= 1;
		LOAD_DATA_I <= 8'hA5;
		pulse;
		chk(REG_Q_O, 8'hA5);
		@(posedge CORE_CLK_I);
		SYNC_CLEAR_I <= 1;
		pulse;
		chk(REG_Q_O, 8'h00);
		$display("t_sync done");
	endtask
	task t_hold;
		@(posedge CORE_CLK_I);
		SYNC_CLEAR_I <= 0;
		BLOCK_CLOCK_ENABLE_ONE_I <= 0;
		BLOCK_CLOCK_ENABLE_TWO_I <= 1;
		pulse;
		chk(REG_Q_O, 8'h00);
		$display("t_hold done");
	endtask
	task t_edge;
		@(posedge CORE_CLK_I);
		CELL_FALL_EDGE_I <= 8'h0F;
		pulse;
		chk({7'h0, EDGE_CONFLICT_O}, 8'h01);
		@(posedge CORE_CLK_I);
		CELL_CLOCK_SEL_I <= 8'h0F;
		pulse;
		chk({7'h0, EDGE_CONFLICT_O}, 8'h00);
		$display("t_edge done");
	endtask
	// sum of two words through the count and carry tables, no cascade
	task t_comb;
		@(posedge CORE_CLK_I);
		CASCADE_USE_I <= 8'h00;
		COUNT_LUT_I <= 8'h96;
		CARRY_LUT_I <= 8'hE8;
		DATA_A_I <= 8'h0F;
		DATA_B_I <= 8'h01;
		pulse;
		chk(COMB_O, 8'h10);
		chk({7'h0, CARRY_OUT_O}, 8'h00);
		chk({CTRL_OVER_O, 3'h0, CTRL_USED_O}, 8'h04);
		@(posedge CORE_CLK_I);
		DATA_A_I <= 8'hFF;
		pulse;
		chk(COMB_O, 8'h00);
		chk({7'h0, CARRY_OUT_O}, 8'h01);
		$display("t_comb done");
	endtask
	// device clear held low against every other control except sync clear
	task clr(input logic [15:0] m, input logic [7:0] eq, input logic [7:0] eu);
		@(posedge CORE_CLK_I);
		CELL_MODE_I <= m;
		DEVICE_WIDE_CLEAR_N_I <= 0;
		{ASYNC_CLEAR_I, ASYNC_PRESET_I, ASYNC_LOAD_I} <= 3'h7;
		{BLOCK_CLOCK_ENABLE_ONE_I, LOAD_DATA_I} <= 9'h1FF;
		pulse;
		if (eu === 8'h00)
			chk(REG_Q_O, eq);
		chk(UNKNOWN_O, eu);
		chk({2'h0, EXTRA_CELLS_O}, (m == 0) ? 8'h00 : 8'h18);
		chk({CTRL_OVER_O, 3'h0, CTRL_USED_O}, 8'h88);
	endtask
	initial begin
		repeat (6) @(posedge CORE_CLK_I);
		RST_I <= 0;
		t_sync;
		t_hold;
		t_edge;
		t_comb;
		clr(16'h0000, 8'h00, 8'h00);
		clr(16'h5555, 8'hFF, 8'h00);
		clr(16'hAAAA, 8'hFF, 8'h00);
		clr(16'hFFFF, 8'h00, 8'hFF);
		$display("t_clear done");
		report_and_stop;
	end
	always @(posedge CORE_CLK_I) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			report_and_stop;
		end
	end
endmodule
`default_nettype wire
